// ### hdl/pwm_ctrl_pkg.sv
// Shared constants for the six-channel pulse-width modulator control block
package pwm_ctrl_pkg;

  localparam int NUM_CH   = 6;
  localparam int ADR_W    = 8;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 8;
  localparam int PRESC_W  = 7;
  localparam int RATE_W   = 3;

  // Byte offsets of the word registers
  localparam logic [ADR_W-1:0] OFS_POLARITY    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CLK_SELECT  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PRESCALE    = 8'h08;
  localparam logic [ADR_W-1:0] OFS_RUN         = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_STATUS      = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PERIOD_BASE = 8'h20;
  localparam logic [ADR_W-1:0] OFS_DUTY_BASE   = 8'h40;

  // Field positions
  localparam int RATE_A_LSB      = 0;
  localparam int RATE_B_LSB      = 4;
  localparam int STAT_OUT_LSB    = 0;
  localparam int STAT_ACTIVE_LSB = 8;
  localparam int STAT_PRESC_LSB  = 16;

  // Channels clocked from the B group; the rest use the A group
  localparam logic [NUM_CH-1:0] CLK_GROUP_B = 6'h0C;

  // Reset values
  localparam logic [NUM_CH-1:0] POLARITY_RST   = 6'h00;
  localparam logic [NUM_CH-1:0] CLK_SELECT_RST = 6'h00;
  localparam logic [RATE_W-1:0] RATE_RST       = 3'h0;
  localparam logic [NUM_CH-1:0] RUN_RST        = 6'h00;
  localparam logic [CNT_W-1:0]  PERIOD_RST     = 8'hFF;
  localparam logic [CNT_W-1:0]  DUTY_RST       = 8'h00;

endpackage : pwm_ctrl_pkg

// ### hdl/pwm_channel.sv
// One left-aligned 8-bit modulator channel driven by a selected clock enable
`timescale 1ns/1ns
module pwm_channel #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic             pol_i,
  input  wire logic [CNT_W-1:0] period_i,
  input  wire logic [CNT_W-1:0] duty_i,
  output logic                  out_o,
  output logic                  active_o
);

  if (CNT_W < 2) begin : g_bad_width
    $error("pwm_channel needs CNT_W of at least 2");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} chan_state_t;

  chan_state_t      state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             out_q;

  // Waveform starts only on the first tick after enable, so it lines up with the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (run_i) state_q <= ST_ARMED;
        ST_ARMED: begin
          if (!run_i) state_q <= ST_IDLE;
          else if (tick_i) state_q <= ST_RUN;
        end
        ST_RUN:   if (!run_i) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Period zero wraps through the full count range
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_RUN) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= (cnt_q == period_i - CNT_W'(1)) ? '0 : cnt_q + CNT_W'(1);
    end
  end

  // Polarity is applied live, so a change mid-period may clip one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_RUN) begin
      out_q <= 1'b0;
    end else if (pol_i) begin
      out_q <= (cnt_q < duty_i);
    end else begin
      out_q <= (cnt_q >= duty_i);
    end
  end

  assign out_o    = out_q;
  assign active_o = (state_q == ST_RUN);

  AST_POL_HIGH_START: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RUN && pol_i && cnt_q < duty_i |=> out_o)
    else $error("high-start channel not high before duty");

  AST_POL_LOW_START: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RUN && !pol_i && cnt_q >= duty_i |=> out_o)
    else $error("low-start channel not high after duty");

  AST_POL_CHANGE_KEEPS_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RUN && run_i && $changed(pol_i) |-> ##1 state_q == ST_RUN)
    else $error("polarity change stopped the channel");

  AST_WAIT_FOR_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q != ST_RUN && !tick_i |=> state_q != ST_RUN && !out_o)
    else $error("waveform started without a clock tick");

endmodule : pwm_channel

// ### hdl/pwm_ctrl.sv
// Polarity, clock-select and prescaler control with six modulator channels
`timescale 1ns/1ns
// Contract
// - Polarity set: output high at period start, low once count reaches duty.
// - Polarity clear: output low at period start, high once count reaches duty.
// - Polarity register: one bit per channel, bits 0..5, read and write anytime.
// - Polarity changes accepted while running; one odd pulse may appear.
// - Channels 0,1,4,5: select clear takes clock A, set takes scaled clock A.
// - Channels 2,3: select clear takes clock B, set takes scaled clock B.
// - Clock-select writes accepted anytime; odd pulse at switchover allowed.
// - Bits 2:0 divide bus clock by two to that power for clock A.
// - Bits 6:4 divide bus clock by two to that power for clock B.
// - Clock A feeds only channels 0,1,4,5; clock B only channels 2,3.
// - Prescale writes accepted anytime while channels run.
// - Enabled channel waits for its selected clock's next tick before output.
// - With all six enables clear the prescale counter stops.
module pwm_ctrl
  import pwm_ctrl_pkg::*;
#(
  parameter int CH_CNT_W = CNT_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              scaled_clock_a_i,
  input  wire logic              scaled_clock_b_i,
  output logic      [NUM_CH-1:0] pwm_o
);

  if (CH_CNT_W != CNT_W) begin : g_bad_width
    $error("pwm_ctrl registers are fixed at CNT_W bits");
  end

  logic [NUM_CH-1:0]   channel_polarity_q;
  logic [NUM_CH-1:0]   channel_clock_source_select_q;
  logic [RATE_W-1:0]   rate_a_field_q;
  logic [RATE_W-1:0]   rate_b_field_q;
  logic [NUM_CH-1:0]   channel_run_q;
  logic [CNT_W-1:0]    period_q [NUM_CH];
  logic [CNT_W-1:0]    duty_q   [NUM_CH];
  logic [PRESC_W-1:0]  presc_cnt_q;
  logic                ack_q;
  logic [DATA_W-1:0]   rd_data_q;
  logic [DATA_W-1:0]   rd_data_d;
  logic                bus_req;
  logic                wr_en;
  logic [NUM_CH-1:0]   pwm_out;
  logic [NUM_CH-1:0]   ch_active;
  logic [NUM_CH-1:0]   ch_tick;
  logic                any_run;
  logic                tick_a;
  logic                tick_b;
  logic [PRESC_W-1:0]  mask_a;
  logic [PRESC_W-1:0]  mask_b;
  logic                presc_upset;

  // Wishbone slave: ack one cycle after the request, write at the ack edge
  assign bus_req = wb_cyc_i && wb_stb_i;
  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_en   = bus_req && wb_we_i && ack_q && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= '0;
    end else if (bus_req && !ack_q) begin
      rd_data_q <= rd_data_d;
    end
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_data_d = '0;
    case (wb_adr_i)
      OFS_POLARITY:   rd_data_d[NUM_CH-1:0] = channel_polarity_q;
      OFS_CLK_SELECT: rd_data_d[NUM_CH-1:0] = channel_clock_source_select_q;
      OFS_PRESCALE: begin
        rd_data_d[RATE_A_LSB +: RATE_W] = rate_a_field_q;
        rd_data_d[RATE_B_LSB +: RATE_W] = rate_b_field_q;
      end
      OFS_RUN:        rd_data_d[NUM_CH-1:0] = channel_run_q;
      OFS_STATUS: begin
        rd_data_d[STAT_OUT_LSB +: NUM_CH]     = pwm_out;
        rd_data_d[STAT_ACTIVE_LSB +: NUM_CH]  = ch_active;
        rd_data_d[STAT_PRESC_LSB +: PRESC_W]  = presc_cnt_q;
      end
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (wb_adr_i == OFS_PERIOD_BASE + ADR_W'(4 * i)) begin
            rd_data_d[CNT_W-1:0] = period_q[i];
          end
          if (wb_adr_i == OFS_DUTY_BASE + ADR_W'(4 * i)) begin
            rd_data_d[CNT_W-1:0] = duty_q[i];
          end
        end
      end
    endcase
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_data_q;

  // Control registers; all are writable while channels run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_polarity_q <= POLARITY_RST;
    end else if (wr_en && wb_adr_i == OFS_POLARITY) begin
      channel_polarity_q <= wb_dat_i[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_clock_source_select_q <= CLK_SELECT_RST;
    end else if (wr_en && wb_adr_i == OFS_CLK_SELECT) begin
      channel_clock_source_select_q <= wb_dat_i[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_a_field_q <= RATE_RST;
      rate_b_field_q <= RATE_RST;
    end else if (wr_en && wb_adr_i == OFS_PRESCALE) begin
      rate_a_field_q <= wb_dat_i[RATE_A_LSB +: RATE_W];
      rate_b_field_q <= wb_dat_i[RATE_B_LSB +: RATE_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_run_q <= RUN_RST;
    end else if (wr_en && wb_adr_i == OFS_RUN) begin
      channel_run_q <= wb_dat_i[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        period_q[i] <= PERIOD_RST;
        duty_q[i]   <= DUTY_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wb_adr_i == OFS_PERIOD_BASE + ADR_W'(4 * i)) begin
          period_q[i] <= wb_dat_i[CNT_W-1:0];
        end
        if (wb_adr_i == OFS_DUTY_BASE + ADR_W'(4 * i)) begin
          duty_q[i] <= wb_dat_i[CNT_W-1:0];
        end
      end
    end
  end

  // Prescaler: one counter that runs while any channel is enabled, A and B are enable pulses from it
  assign any_run = |channel_run_q;

  // Held at zero when idle to save toggling power
  always_ff @(posedge clk_i) begin
    if (rst_i || !any_run) begin
      presc_cnt_q <= '0;
    end else begin
      presc_cnt_q <= presc_cnt_q + PRESC_W'(1);
    end
  end

  function automatic logic [PRESC_W-1:0] rate_mask(input logic [RATE_W-1:0] rate);
    logic [PRESC_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRESC_W; i++) begin
      m[i] = (RATE_W'(i) < rate);
    end
    return m;
  endfunction : rate_mask

  assign mask_a = rate_mask(rate_a_field_q);
  assign mask_b = rate_mask(rate_b_field_q);
  // A pulse each time the low bits roll over gives bus clock over 2**rate
  assign tick_a = any_run && (&(presc_cnt_q | ~mask_a));
  assign tick_b = any_run && (&(presc_cnt_q | ~mask_b));
  // Rate or run writes may legally break the tick spacing, so spacing checks stand down then
  assign presc_upset = wr_en && (wb_adr_i == OFS_PRESCALE || wb_adr_i == OFS_RUN);

  // Channels with per-channel clock choice
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    if (CLK_GROUP_B[c]) begin : g_grp_b
      assign ch_tick[c] = channel_clock_source_select_q[c] ? scaled_clock_b_i : tick_b;
    end else begin : g_grp_a
      assign ch_tick[c] = channel_clock_source_select_q[c] ? scaled_clock_a_i : tick_a;
    end

    pwm_channel #(
      .CNT_W(CNT_W)
    ) u_channel (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (channel_run_q[c]),
      .tick_i  (ch_tick[c]),
      .pol_i   (channel_polarity_q[c]),
      .period_i(period_q[c]),
      .duty_i  (duty_q[c]),
      .out_o   (pwm_out[c]),
      .active_o(ch_active[c])
    );
  end

  assign pwm_o = pwm_out;

  // Checks
  AST_POL_WRITE_STORED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == OFS_POLARITY |=> channel_polarity_q == $past(wb_dat_i[NUM_CH-1:0]))
    else $error("polarity write not stored");

  AST_CH0_CLOCK_A: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_clock_source_select_q[0] && !tick_a |-> !ch_tick[0])
    else $error("channel 0 ticked without clock A");

  AST_CH4_SCALED_A: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_clock_source_select_q[4] |-> ch_tick[4] == scaled_clock_a_i)
    else $error("channel 4 not on scaled clock A");

  AST_CH2_CLOCK_B: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_clock_source_select_q[2] |-> ch_tick[2] == tick_b && (ch_tick[2] || !tick_b))
    else $error("channel 2 not on clock B");

  AST_CH3_SCALED_B: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_clock_source_select_q[3] && !scaled_clock_b_i |-> !ch_tick[3])
    else $error("channel 3 ticked without scaled clock B");

  AST_RATE_A_UNDIVIDED: assert property (@(posedge clk_i) disable iff (rst_i)
    any_run && rate_a_field_q == 3'h0 |-> tick_a)
    else $error("undivided clock A missed a cycle");

  AST_RATE_A_DIV8: assert property (@(posedge clk_i) disable iff (rst_i || presc_upset)
    tick_a && rate_a_field_q == 3'h3 && !wr_en |=> !tick_a [*7] ##1 tick_a)
    else $error("clock A divide by 8 spacing wrong");

  AST_RATE_B_DIV2: assert property (@(posedge clk_i) disable iff (rst_i || presc_upset)
    tick_b && rate_b_field_q == 3'h1 && !wr_en |=> !tick_b ##1 tick_b)
    else $error("clock B divide by 2 spacing wrong");

  AST_PRESC_STOPS: assert property (@(posedge clk_i) disable iff (rst_i)
    !any_run |-> (!tick_a && !tick_b) ##1 presc_cnt_q == '0)
    else $error("prescaler ran with all channels off");

  AST_ACK_ONE_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged after one wait");

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");

  AST_POL_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_POLARITY |-> wb_dat_o == DATA_W'(channel_polarity_q))
    else $error("polarity read data wrong");

  AST_CLKSEL_WRITE_STORED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == OFS_CLK_SELECT |=> channel_clock_source_select_q == $past(wb_dat_i[NUM_CH-1:0]))
    else $error("clock select write not stored");

  AST_PRESC_WRITE_STORED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == OFS_PRESCALE |=> rate_a_field_q == $past(wb_dat_i[RATE_A_LSB +: RATE_W])
      && rate_b_field_q == $past(wb_dat_i[RATE_B_LSB +: RATE_W]))
    else $error("prescale write not stored");

  AST_RUN_WRITE_STORED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == OFS_RUN |=> channel_run_q == $past(wb_dat_i[NUM_CH-1:0]))
    else $error("run enable write not stored");

  AST_RESET_VALUES: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> channel_polarity_q == POLARITY_RST && channel_clock_source_select_q == CLK_SELECT_RST
      && rate_a_field_q == RATE_RST && rate_b_field_q == RATE_RST)
    else $error("control fields not cleared by reset");

  AST_CH1_CLOCK_A: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_clock_source_select_q[1] |-> ch_tick[1] == tick_a)
    else $error("channel 1 not on clock A");

  AST_CH5_CLOCK_A: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_clock_source_select_q[5] |-> ch_tick[5] == tick_a)
    else $error("channel 5 not on clock A");

  AST_CH3_CLOCK_B: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_clock_source_select_q[3] |-> ch_tick[3] == tick_b)
    else $error("channel 3 not on clock B");

  AST_CH5_SCALED_A: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_clock_source_select_q[5] |-> ch_tick[5] == scaled_clock_a_i)
    else $error("channel 5 not on scaled clock A");

  AST_CH2_SCALED_B: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_clock_source_select_q[2] |-> ch_tick[2] == scaled_clock_b_i)
    else $error("channel 2 not on scaled clock B");

  AST_RATE_B_UNDIVIDED: assert property (@(posedge clk_i) disable iff (rst_i)
    any_run && rate_b_field_q == 3'h0 |-> tick_b)
    else $error("undivided clock B missed a cycle");

  AST_RATE_A_DIV2: assert property (@(posedge clk_i) disable iff (rst_i || presc_upset)
    tick_a && rate_a_field_q == 3'h1 |=> !tick_a ##1 tick_a)
    else $error("clock A divide by 2 spacing wrong");

  AST_PRESC_COUNTS: assert property (@(posedge clk_i) disable iff (rst_i)
    any_run |=> presc_cnt_q == $past(presc_cnt_q) + PRESC_W'(1))
    else $error("prescale counter did not advance");

  // Stopped channels park their outputs low whatever the polarity
  for (genvar c = 0; c < NUM_CH; c++) begin : g_idle_chk
    AST_IDLE_OUTPUT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      !channel_run_q[c] |=> ##1 !pwm_out[c])
      else $error("stopped channel output not low");
  end

  COV_CH0_OUTPUT: cover property (@(posedge clk_i) disable iff (rst_i)
    ch_active[0] && $rose(pwm_out[0]));

  COV_POL_WRITE_RUNNING: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wb_adr_i == OFS_POLARITY && |ch_active);

  COV_SCALED_B_USED: cover property (@(posedge clk_i) disable iff (rst_i)
    channel_clock_source_select_q[2] && ch_active[2] && ch_tick[2]);

  COV_RATE_A_MAX: cover property (@(posedge clk_i) disable iff (rst_i)
    rate_a_field_q == 3'h7 && tick_a);

  COV_RATE_B_MAX: cover property (@(posedge clk_i) disable iff (rst_i)
    rate_b_field_q == 3'h7 && tick_b);

endmodule : pwm_ctrl

// ### verif/tb_pwm_ctrl.sv
// Self-checking bench for the modulator control block: registers, prescale rates, polarity, clock choice
`timescale 1ns/1ns
module tb_pwm_ctrl;
  import pwm_ctrl_pkg::*;

  localparam int PER  = 4;
  localparam int DUTY = 1;

  logic              clk_i            = 1'b0;
  logic              rst_i            = 1'b1;
  logic              wb_cyc_i         = 1'b0;
  logic              wb_stb_i         = 1'b0;
  logic              wb_we_i          = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i         = '0;
  logic [3:0]        wb_sel_i         = 4'hF;
  logic [DATA_W-1:0] wb_dat_i         = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic              wb_ack_o;
  logic              scaled_clock_a_i = 1'b0;
  logic              scaled_clock_b_i = 1'b0;
  logic [NUM_CH-1:0] pwm_o;

  int                n_mismatch = 0;
  int                n_checks   = 0;
  int                cyc_n      = 0;
  int                rise_t[NUM_CH];
  int                per_seen[NUM_CH];
  int                high_seen[NUM_CH];
  logic [NUM_CH-1:0] prev_out   = '0;
  logic [15:0]       lfsr_q     = 16'hC215;
  logic              scaled_on  = 1'b0;
  int                sa_cnt     = 0;
  int                sb_cnt     = 0;
  logic [31:0]       rd;

  pwm_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scaled_clock_a_i(scaled_clock_a_i), .scaled_clock_b_i(scaled_clock_b_i),
    .pwm_o(pwm_o)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Outputs sampled mid-cycle so register updates at the rising edge have settled
  always @(negedge clk_i) begin
    cyc_n++;
    for (int c = 0; c < NUM_CH; c++) begin
      if (pwm_o[c] === 1'b1 && prev_out[c] === 1'b0) begin
        per_seen[c] = cyc_n - rise_t[c];
        rise_t[c]   = cyc_n;
      end
      if (pwm_o[c] === 1'b0 && prev_out[c] === 1'b1) high_seen[c] = cyc_n - rise_t[c];
    end
    prev_out = pwm_o;
  end

  // Scaled ticks stand in for the external scaler: A every 3 cycles, B every 5
  always @(posedge clk_i) begin
    sa_cnt           <= (sa_cnt == 2) ? 0 : sa_cnt + 1;
    sb_cnt           <= (sb_cnt == 4) ? 0 : sb_cnt + 1;
    scaled_clock_a_i <= scaled_on && sa_cnt == 2;
    scaled_clock_b_i <= scaled_on && sb_cnt == 4;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    // Ack and read data are seen as they stood at each rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("Error bus ack expected 1 seen none");
      report_and_stop();
    end
    data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
    logic [31:0] dummy;
    wb_xfer(1'b1, adr, dat, 4'hF, dummy);
  endtask : wr

  task automatic rd_chk(input string what, input logic [ADR_W-1:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    wb_xfer(1'b0, adr, 32'h0, 4'hF, got);
    check(what, exp, got);
  endtask : rd_chk

  // Model: period = PER ticks, high time from polarity and duty, tick spacing per clock group
  task automatic measure(input logic [NUM_CH-1:0] pol, input int div_a, input int div_b, input int wait_cyc);
    int div;
    wr(OFS_POLARITY, {26'h0, pol});
    repeat (wait_cyc) @(posedge clk_i);
    for (int c = 0; c < NUM_CH; c++) begin
      div = CLK_GROUP_B[c] ? div_b : div_a;
      check("period cycles", PER * div, per_seen[c]);
      check("high cycles", pol[c] ? DUTY * div : (PER - DUTY) * div, high_seen[c]);
    end
  endtask : measure

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("polarity reset", OFS_POLARITY, 32'h0);
    rd_chk("clock select reset", OFS_CLK_SELECT, 32'h0);
    rd_chk("prescale reset", OFS_PRESCALE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(OFS_POLARITY, {16'h0, lfsr_q});
      rd_chk("polarity", OFS_POLARITY, {26'h0, lfsr_q[5:0]});
      wr(OFS_CLK_SELECT, {lfsr_q, 16'h0});
      rd_chk("clock select", OFS_CLK_SELECT, 32'h0);
      wr(OFS_CLK_SELECT, {16'h0, lfsr_q});
      rd_chk("clock select", OFS_CLK_SELECT, {26'h0, lfsr_q[5:0]});
      wr(OFS_PRESCALE, {16'h0, lfsr_q});
      rd_chk("prescale", OFS_PRESCALE, {25'h0, lfsr_q[6:4], 1'b0, lfsr_q[2:0]});
    end
    wb_xfer(1'b1, OFS_POLARITY, ~{16'h0, lfsr_q}, 4'hE, rd);
    rd_chk("polarity low byte off", OFS_POLARITY, {26'h0, lfsr_q[5:0]});
    rd_chk("unmapped", 8'h14, 32'h0);
    for (int c = 0; c < NUM_CH; c++) begin
      wr(OFS_PERIOD_BASE + ADR_W'(4 * c), PER);
      wr(OFS_DUTY_BASE + ADR_W'(4 * c), DUTY);
    end
    wr(OFS_CLK_SELECT, 32'h0);
    wr(OFS_RUN, 32'h3F);
    for (int r = 0; r < 8; r++) begin
      wr(OFS_PRESCALE, 32'((7 - r) << RATE_B_LSB | r));
      measure(r[0] ? 6'h15 : 6'h2A, 1 << r, 1 << (7 - r), 3 * PER * 128);
    end
    scaled_on <= 1'b1;
    wr(OFS_CLK_SELECT, 32'h3F);
    measure(6'h0F, 3, 5, 12 * PER * 5);
    wr(OFS_RUN, 32'h0);
    repeat (4) @(posedge clk_i);
    rd_chk("status idle", OFS_STATUS, 32'h0);
    repeat (9) @(posedge clk_i);
    rd_chk("status idle", OFS_STATUS, 32'h0);
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    $display("Error run length expected end seen none");
    report_and_stop();
  end

endmodule : tb_pwm_ctrl
